// ==== design/interrupt_priority_levels.sv ====
// Interrupt priority level registers with an AXI4-Lite slave and preemptive level arbitration.
// Summary of operation
// R1 - The low level register holds the lower level bit of each source: counter array bit 6 down to external 0 bit 0.
// R2 - The high level register holds the upper level bit of each source in the same bit layout.
// R3 - A source's level is its high bit above its low bit, 00 lowest through 11 highest.
// R4 - Bit 7 of both registers is reserved, is never stored, and software must not write a one there.
// R5 - Reset clears bits 6..0 of both registers; only the low register allows single-bit writes.
// R6 - A request at a higher level preempts a lower running routine; equal levels wait for the return.
`timescale 1ns/10ps
module interrupt_priority_levels
   import irq_level_pkg::*;
(
   input  wire logic                  SYS_CLK,        // System clock, 200 MHz.
   input  wire logic                  RST,            // Asynchronous reset, active high.
   input  wire logic [ADDR_W-1:0]     S_AXI_AWADDR,   // Write address.
   input  wire logic                  S_AXI_AWVALID,  // Write address valid.
   output logic                       S_AXI_AWREADY,  // Write address ready.
   input  wire logic [DATA_W-1:0]     S_AXI_WDATA,    // Write data.
   input  wire logic [DATA_W/8-1:0]   S_AXI_WSTRB,    // Write byte strobes.
   input  wire logic                  S_AXI_WVALID,   // Write data valid.
   output logic                       S_AXI_WREADY,   // Write data ready.
   output logic [1:0]                 S_AXI_BRESP,    // Write response.
   output logic                       S_AXI_BVALID,   // Write response valid.
   input  wire logic                  S_AXI_BREADY,   // Write response ready.
   input  wire logic [ADDR_W-1:0]     S_AXI_ARADDR,   // Read address.
   input  wire logic                  S_AXI_ARVALID,  // Read address valid.
   output logic                       S_AXI_ARREADY,  // Read address ready.
   output logic [DATA_W-1:0]          S_AXI_RDATA,    // Read data.
   output logic [1:0]                 S_AXI_RRESP,    // Read response.
   output logic                       S_AXI_RVALID,   // Read data valid.
   input  wire logic                  S_AXI_RREADY,   // Read data ready.
   input  wire logic [NUM_SRC-1:0]    IRQ_REQ,        // Pending requests from the sources.
   input  wire logic                  IRQ_RETURN,     // Pulse: current service routine returns.
   output logic [NUM_SRC-1:0]         LEVEL_HIGH,     // Upper level bits to the core.
   output logic [NUM_SRC-1:0]         LEVEL_LOW,      // Lower level bits to the core.
   output logic                       GRANT,          // Pulse: a request is taken into service.
   output logic [2:0]                 GRANT_SRC,      // Source of the last grant.
   output logic [1:0]                 GRANT_LEVEL,    // Level of the last grant.
   output logic [NUM_LEVELS-1:0]      IN_SERVICE      // Levels currently in service.
);

   logic [NUM_SRC-1:0]  level_high_r;
   logic [NUM_SRC-1:0]  level_low_r;
   logic [NUM_SRC-1:0]  level_high_nxt;
   logic [NUM_SRC-1:0]  level_low_nxt;

   logic                awready_r;
   logic                wready_r;
   logic                aw_full_r;
   logic                w_full_r;
   logic [ADDR_W-1:0]   waddr_r;
   logic [DATA_W-1:0]   wdata_r;
   logic                wlane_r;
   logic                bvalid_r;
   logic [1:0]          bresp_r;
   logic                arready_r;
   logic                rvalid_r;
   logic [DATA_W-1:0]   rdata_r;
   logic [1:0]          rresp_r;

   logic                grant_r;
   logic [2:0]          grant_src_r;
   logic [1:0]          grant_level_r;
   logic [NUM_LEVELS-1:0] in_service_r;

   // Handshake and decode terms.
   wire aw_take   = S_AXI_AWVALID && awready_r;
   wire w_take    = S_AXI_WVALID && wready_r;
   wire ar_take   = S_AXI_ARVALID && arready_r;
   wire b_done    = bvalid_r && S_AXI_BREADY;
   wire r_done    = rvalid_r && S_AXI_RREADY;
   wire do_write  = aw_full_r && w_full_r && !bvalid_r;

   wire wr_high   = do_write && waddr_r == LEVEL_HIGH_ADDR;
   wire wr_low    = do_write && waddr_r == LEVEL_LOW_ADDR;
   wire wr_bit    = do_write && waddr_r == BIT_ACCESS_ADDR;
   wire wr_status = do_write && waddr_r == STATUS_ADDR;
   wire wr_mapped = wr_high || wr_low || wr_bit || wr_status;

   wire rd_high   = S_AXI_ARADDR == LEVEL_HIGH_ADDR;
   wire rd_low    = S_AXI_ARADDR == LEVEL_LOW_ADDR;
   wire rd_bit    = S_AXI_ARADDR == BIT_ACCESS_ADDR;
   wire rd_status = S_AXI_ARADDR == STATUS_ADDR;
   wire rd_mapped = rd_high || rd_low || rd_bit || rd_status;

   // Bit 7 is never stored, so a stray one written there has no effect.
   wire [NUM_SRC-1:0] wr_byte = wdata_r[NUM_SRC-1:0];                      // [R4]

   // Single-bit access to the low register; a select of 7 touches nothing.
   wire [BIT_SEL_W-1:0] bit_sel = wdata_r[BIT_SEL_LSB +: BIT_SEL_W];
   wire                 bit_val = wdata_r[BIT_VAL_POS];
   wire [NUM_SRC-1:0]   bit_mask = NUM_SRC'(1) << bit_sel;
   wire [NUM_SRC-1:0]   low_bit_upd = bit_val ? (level_low_r | bit_mask) : (level_low_r & ~bit_mask);

   // The high register is written only as a whole byte.
   assign level_high_nxt = (wr_high && wlane_r) ? wr_byte : level_high_r;   // [R2] [R5]
   assign level_low_nxt  = (wr_low && wlane_r) ? wr_byte :                  // [R1]
                           (wr_bit && wlane_r) ? low_bit_upd :              // [R5]
                           level_low_r;

   // Reserved bit 7 and everything above the level bits read as zero.
   wire [DATA_W-1:0] status_word = (DATA_W'(in_service_r) << STAT_INSERV_LSB)
                                 | (DATA_W'(grant_src_r) << STAT_SRC_LSB)
                                 | (DATA_W'(|in_service_r) << STAT_BUSY_POS)
                                 | (DATA_W'(grant_level_r) << STAT_LEVEL_LSB);
   wire [DATA_W-1:0] rd_word = rd_high   ? DATA_W'(level_high_r) :         // [R4]
                               rd_low    ? DATA_W'(level_low_r) :
                               rd_status ? status_word :
                               '0;

   // Level registers.
   always_ff @(posedge SYS_CLK or posedge RST)
   begin
      if (RST)
      begin
         level_high_r <= LEVEL_RESET;                                       // [R5]
         level_low_r  <= LEVEL_RESET;                                       // [R5]
      end
      else
      begin
         level_high_r <= level_high_nxt;
         level_low_r  <= level_low_nxt;
      end
   end

   // Write channels: address and data are caught independently, then answered together.
   always_ff @(posedge SYS_CLK or posedge RST)
   begin
      if (RST)
      begin
         awready_r <= 1'b1;
         wready_r  <= 1'b1;
         aw_full_r <= 1'b0;
         w_full_r  <= 1'b0;
         waddr_r   <= '0;
         wdata_r   <= '0;
         wlane_r   <= 1'b0;
         bvalid_r  <= 1'b0;
         bresp_r   <= RESP_OKAY;
      end
      else
      begin
         if (aw_take)
         begin
            awready_r <= 1'b0;
            aw_full_r <= 1'b1;
            waddr_r   <= S_AXI_AWADDR;
         end
         if (w_take)
         begin
            wready_r <= 1'b0;
            w_full_r <= 1'b1;
            wdata_r  <= S_AXI_WDATA;
            wlane_r  <= S_AXI_WSTRB[LANE_ZERO];
         end
         if (do_write)
         begin
            aw_full_r <= 1'b0;
            w_full_r  <= 1'b0;
            bvalid_r  <= 1'b1;
            bresp_r   <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
         end
         if (b_done)
         begin
            bvalid_r  <= 1'b0;
            awready_r <= 1'b1;
            wready_r  <= 1'b1;
         end
      end
   end

   // Read channel: data is returned on the edge that takes the address.
   always_ff @(posedge SYS_CLK or posedge RST)
   begin
      if (RST)
      begin
         arready_r <= 1'b1;
         rvalid_r  <= 1'b0;
         rdata_r   <= '0;
         rresp_r   <= RESP_OKAY;
      end
      else
      begin
         if (ar_take)
         begin
            arready_r <= 1'b0;
            rvalid_r  <= 1'b1;
            rdata_r   <= rd_word;
            rresp_r   <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
         end
         if (r_done)
         begin
            rvalid_r  <= 1'b0;
            arready_r <= 1'b1;
         end
      end
   end

   level_arbiter u_arbiter
   (
      .clk           (SYS_CLK),
      .rst           (RST),
      .req           (IRQ_REQ),
      .lvl_high      (level_high_r),
      .lvl_low       (level_low_r),
      .service_done  (IRQ_RETURN),
      .grant_r       (grant_r),
      .grant_src_r   (grant_src_r),
      .grant_level_r (grant_level_r),
      .in_service_r  (in_service_r)
   );

   assign S_AXI_AWREADY = awready_r;
   assign S_AXI_WREADY  = wready_r;
   assign S_AXI_BVALID  = bvalid_r;
   assign S_AXI_BRESP   = bresp_r;
   assign S_AXI_ARREADY = arready_r;
   assign S_AXI_RVALID  = rvalid_r;
   assign S_AXI_RDATA   = rdata_r;
   assign S_AXI_RRESP   = rresp_r;
   assign LEVEL_HIGH    = level_high_r;
   assign LEVEL_LOW     = level_low_r;
   assign GRANT         = grant_r;
   assign GRANT_SRC     = grant_src_r;
   assign GRANT_LEVEL   = grant_level_r;
   assign IN_SERVICE    = in_service_r;

endmodule

// ==== design/irq_level_pkg.sv ====
// Constants shared by the interrupt priority level block and its arbiter.
package irq_level_pkg;

   // Number of interrupt sources and their bit positions in both level registers.
   localparam int NUM_SRC                    = 7;
   localparam logic [2:0] SRC_EXT_ZERO       = 3'h0;
   localparam logic [2:0] SRC_TIMER_ZERO     = 3'h1;
   localparam logic [2:0] SRC_EXT_ONE        = 3'h2;
   localparam logic [2:0] SRC_TIMER_ONE      = 3'h3;
   localparam logic [2:0] SRC_SERIAL_PORT    = 3'h4;
   localparam logic [2:0] SRC_TIMER_TWO      = 3'h5;
   localparam logic [2:0] SRC_COUNTER_ARRAY  = 3'h6;

   // Two-bit priority levels, lowest to highest.
   localparam int NUM_LEVELS                 = 4;
   localparam logic [1:0] LEVEL_LOWEST       = 2'h0;
   localparam logic [1:0] LEVEL_HIGHEST      = 2'h3;

   // Register indices; the byte address is four times the index.
   localparam int ADDR_W                     = 12;
   localparam logic [7:0] LEVEL_HIGH_INDEX   = 8'hB7;
   localparam logic [7:0] LEVEL_LOW_INDEX    = 8'hB8;
   localparam logic [ADDR_W-1:0] LEVEL_HIGH_ADDR = {2'h0, LEVEL_HIGH_INDEX, 2'h0};
   localparam logic [ADDR_W-1:0] LEVEL_LOW_ADDR  = {2'h0, LEVEL_LOW_INDEX, 2'h0};
   localparam logic [ADDR_W-1:0] BIT_ACCESS_ADDR = 12'h300;
   localparam logic [ADDR_W-1:0] STATUS_ADDR     = 12'h304;

   // Reset value of the implemented bits 6..0.
   localparam logic [NUM_SRC-1:0] LEVEL_RESET = 7'h00;

   // Single-bit access word: bit select in [2:0], value in [3].
   localparam int BIT_SEL_LSB                = 0;
   localparam int BIT_SEL_W                  = 3;
   localparam int BIT_VAL_POS                = 3;

   // Status word fields.
   localparam int STAT_INSERV_LSB            = 0;
   localparam int STAT_SRC_LSB               = 4;
   localparam int STAT_BUSY_POS              = 7;
   localparam int STAT_LEVEL_LSB             = 8;

   // Bus constants.
   localparam int DATA_W                     = 32;
   localparam int LANE_ZERO                  = 0;
   localparam logic [1:0] RESP_OKAY          = 2'h0;
   localparam logic [1:0] RESP_SLVERR        = 2'h2;

endpackage

// ==== design/level_arbiter.sv ====
// Picks the highest pending request and tracks which priority levels are in service.
`timescale 1ns/10ps
module level_arbiter
   import irq_level_pkg::*;
(
   input  wire logic                  clk,            // System clock.
   input  wire logic                  rst,            // Asynchronous reset, active high.
   input  wire logic [NUM_SRC-1:0]    req,            // Pending requests, one per source.
   input  wire logic [NUM_SRC-1:0]    lvl_high,       // Upper level bit per source.
   input  wire logic [NUM_SRC-1:0]    lvl_low,        // Lower level bit per source.
   input  wire logic                  service_done,   // Return from the current routine.
   output logic                       grant_r,        // One-cycle grant pulse.
   output logic [2:0]                 grant_src_r,    // Source of the last grant.
   output logic [1:0]                 grant_level_r,  // Level of the last grant.
   output logic [NUM_LEVELS-1:0]      in_service_r    // One bit per level in service.
);

   // Returns {found, level, source}; on equal levels the lower source number wins.
   function automatic logic [5:0] pick_best(input logic [NUM_SRC-1:0] r,
                                            input logic [NUM_SRC-1:0] hi,
                                            input logic [NUM_SRC-1:0] lo);
      logic       found;
      logic [1:0] best_lvl;
      logic [2:0] best_src;
      logic [1:0] l;
      found    = 1'b0;
      best_lvl = LEVEL_LOWEST;
      best_src = SRC_EXT_ZERO;
      l        = LEVEL_LOWEST;
      for (int i = 0; i < NUM_SRC; i++)
      begin
         l = {hi[i], lo[i]};                                   // [R3]
         if (r[i] && (!found || l > best_lvl))
         begin
            found    = 1'b1;
            best_lvl = l;
            best_src = 3'(i);
         end
      end
      return {found, best_lvl, best_src};
   endfunction

   // Returns {any, highest level} of a set of in-service bits.
   function automatic logic [2:0] top_level(input logic [NUM_LEVELS-1:0] m);
      logic       any;
      logic [1:0] lvl;
      any = 1'b0;
      lvl = LEVEL_LOWEST;
      for (int i = 0; i < NUM_LEVELS; i++)
      begin
         if (m[i])
         begin
            any = 1'b1;
            lvl = 2'(i);
         end
      end
      return {any, lvl};
   endfunction

   logic [5:0]            best;
   logic [2:0]            top;
   logic                  grant_now;
   logic [NUM_LEVELS-1:0] set_mask;
   logic [NUM_LEVELS-1:0] clr_mask;
   logic [NUM_LEVELS-1:0] in_service_nxt;

   assign best      = pick_best(req, lvl_high, lvl_low);
   assign top       = top_level(in_service_r);
   // Only a strictly higher level interrupts a running routine.
   assign grant_now = best[5] && (!top[2] || best[4:3] > top[1:0]);       // [R6]
   assign set_mask  = grant_now ? (NUM_LEVELS'(1) << best[4:3]) : '0;
   assign clr_mask  = (service_done && top[2]) ? (NUM_LEVELS'(1) << top[1:0]) : '0;
   assign in_service_nxt = (in_service_r & ~clr_mask) | set_mask;           // [R6]

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         grant_r       <= 1'b0;
         grant_src_r   <= SRC_EXT_ZERO;
         grant_level_r <= LEVEL_LOWEST;
         in_service_r  <= '0;
      end
      else
      begin
         grant_r      <= grant_now;
         in_service_r <= in_service_nxt;
         if (grant_now)
         begin
            grant_src_r   <= best[2:0];
            grant_level_r <= best[4:3];
         end
      end
   end

endmodule

// ==== sim/irq_level_checker.sv ====
// Port checks for the interrupt priority level block.
`timescale 1ns/10ps
module irq_level_checker
   import irq_level_pkg::*;
(
   input wire logic                  SYS_CLK,        // Clock.
   input wire logic                  RST,            // Reset.
   input wire logic                  S_AXI_AWVALID,  // AW valid.
   input wire logic                  S_AXI_AWREADY,  // AW ready.
   input wire logic                  S_AXI_WVALID,   // W valid.
   input wire logic                  S_AXI_WREADY,   // W ready.
   input wire logic                  S_AXI_BVALID,   // B valid.
   input wire logic                  S_AXI_ARVALID,  // AR valid.
   input wire logic                  S_AXI_ARREADY,  // AR ready.
   input wire logic                  S_AXI_RVALID,   // R valid.
   input wire logic [NUM_SRC-1:0]    IRQ_REQ,        // Requests.
   input wire logic                  IRQ_RETURN,     // Return.
   input wire logic [NUM_SRC-1:0]    LEVEL_HIGH,     // Upper bits.
   input wire logic [NUM_SRC-1:0]    LEVEL_LOW,      // Lower bits.
   input wire logic                  GRANT,          // Grant.
   input wire logic [2:0]            GRANT_SRC,      // Source.
   input wire logic [1:0]            GRANT_LEVEL,    // Level.
   input wire logic [NUM_LEVELS-1:0] IN_SERVICE      // In service.
);
   logic [NUM_SRC-1:0] high_r;
   logic [NUM_SRC-1:0] low_r;
   logic [NUM_SRC-1:0] req_r;
   // Grants are decided on the inputs seen one edge earlier.
   always_ff @(posedge SYS_CLK)
   begin
      high_r <= LEVEL_HIGH;
      low_r  <= LEVEL_LOW;
      req_r  <= IRQ_REQ;
   end
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (RST);
   sequence s_wr_take;
      S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
   endsequence
   property p_lvl_hold;
      !$rose(S_AXI_BVALID) |-> $stable(LEVEL_HIGH) && $stable(LEVEL_LOW);
   endproperty
   property p_wr_resp;
      s_wr_take |-> ##2 S_AXI_BVALID;
   endproperty
   property p_rd_resp;
      S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID;
   endproperty
   property p_grant_req;
      GRANT |-> req_r[GRANT_SRC];
   endproperty
   property p_grant_above;
      GRANT |-> ($past(IN_SERVICE) >> GRANT_LEVEL) == 4'h0;
   endproperty
   property p_grant_mark;
      GRANT |-> IN_SERVICE[GRANT_LEVEL];
   endproperty
   property p_grant_level;
      GRANT |-> GRANT_LEVEL == {high_r[GRANT_SRC], low_r[GRANT_SRC]};
   endproperty
   property p_ret_clear;
      IRQ_RETURN && IN_SERVICE == 4'h3 && IRQ_REQ == 7'h00 |=> IN_SERVICE == 4'h1;
   endproperty
   a_lvl_hold: assert property (p_lvl_hold) else $error("levels moved without a write");
   a_wr_resp: assert property (p_wr_resp) else $error("write response late");
   a_rd_resp: assert property (p_rd_resp) else $error("read response late");
   a_grant_req: assert property (p_grant_req) else $error("grant without request");
   a_grant_above: assert property (p_grant_above) else $error("grant not above served level");
   a_grant_mark: assert property (p_grant_mark) else $error("granted level not in service");
   a_grant_level: assert property (p_grant_level) else $error("grant level wrong");
   a_ret_clear: assert property (p_ret_clear) else $error("return did not clear top level");
endmodule

// ==== sim/irq_source_model.sv ====
// Request sources and service returns on the core side.
`timescale 1ns/10ps
module irq_source_model
   import irq_level_pkg::*;
(
   input  wire logic               clk,        // Clock.
   input  wire logic               grant,      // Grant pulse.
   input  wire logic [2:0]         grant_src,  // Granted source.
   output logic      [NUM_SRC-1:0] req,        // Requests.
   output logic                    ret         // Return pulse.
);
   initial
   begin
      req = 7'h00;
      ret = 1'b0;
   end
   // A served request is withdrawn so it is not taken again after the return.
   always @(posedge clk)
      if (grant)
         req[grant_src] <= 1'b0;
   task automatic raise(input int s);
      @(posedge clk);
      req[s] <= 1'b1;
   endtask
   task automatic give_back();
      @(posedge clk);
      ret <= 1'b1;
      @(posedge clk);
      ret <= 1'b0;
   endtask
endmodule

// ==== sim/tb_interrupt_priority_levels.sv ====
// Self-checking bench for the interrupt priority level block.
`timescale 1ns/10ps
module tb_interrupt_priority_levels
   import irq_level_pkg::*;
   ;
   logic                    clk = 1'b0;
   logic                    rst = 1'b1;
   logic [ADDR_W-1:0]       awaddr = 12'h000;
   logic [ADDR_W-1:0]       araddr = 12'h000;
   logic [DATA_W-1:0]       wdata = 32'h0;
   logic [3:0]              wstrb = 4'h0;
   logic                    awvalid = 1'b0;
   logic                    wvalid = 1'b0;
   logic                    bready = 1'b0;
   logic                    arvalid = 1'b0;
   logic                    rready = 1'b0;
   wire logic               awready, wready, bvalid, arready, rvalid, grant, ret;
   wire logic [1:0]         bresp, rresp, glvl;
   wire logic [DATA_W-1:0]  rdata;
   wire logic [NUM_SRC-1:0] req, lvh, lvl;
   wire logic [2:0]         gsrc;
   wire logic [3:0]         insv;
   int                      n_errors = 0;
   int                      cmp_count = 0;
   always #2.5 clk = ~clk;
   interrupt_priority_levels i_dut (.SYS_CLK(clk), .RST(rst), .S_AXI_AWADDR(awaddr),
      .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
      .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
      .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
      .IRQ_REQ(req), .IRQ_RETURN(ret), .LEVEL_HIGH(lvh), .LEVEL_LOW(lvl), .GRANT(grant),
      .GRANT_SRC(gsrc), .GRANT_LEVEL(glvl), .IN_SERVICE(insv));
   irq_source_model i_src (.clk(clk), .grant(grant), .grant_src(gsrc), .req(req), .ret(ret));
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e)
      begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
      bit aw;
      bit w;
      @(posedge clk);
      awaddr <= a; wdata <= d; wstrb <= s; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      aw = 1; w = 1;
      while (aw || w)
      begin
         @(posedge clk);
         if (awready) aw = 0;
         if (wready) w = 0;
         awvalid <= aw; wvalid <= w;
      end
      while (bvalid !== 1'b1) @(posedge clk);
      bready <= 1'b0;
      chk("bresp", 32'(er), 32'(bresp));
   endtask
   task automatic axr(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
      @(posedge clk);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      do @(posedge clk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge clk); while (rvalid !== 1'b1);
      rready <= 1'b0;
      chk("rdata", e, rdata);
      chk("rresp", 32'(er), 32'(rresp));
   endtask
   task automatic ports(input logic [6:0] h, input logic [6:0] l);
      chk("level_high", 32'(h), 32'(lvh));
      chk("level_low", 32'(l), 32'(lvl));
   endtask
   task automatic wg(input logic [2:0] s, input logic [1:0] l);
      int n;
      n = 0;
      do @(posedge clk); while (grant !== 1'b1 && ++n < 20);
      chk("grant", 32'h1, 32'(grant));
      chk("grant_src", 32'(s), 32'(gsrc));
      chk("grant_level", 32'(l), 32'(glvl));
   endtask
   task automatic ng();
      repeat (6) @(posedge clk) chk("no grant", 32'h0, 32'(grant));
   endtask
   task automatic t_regs();
      ports(7'h00, 7'h00);
      axr(LEVEL_HIGH_ADDR, 32'h0, RESP_OKAY);
      axr(LEVEL_LOW_ADDR, 32'h0, RESP_OKAY);
      axw(LEVEL_LOW_ADDR, 32'h0000_007F, 4'hF, RESP_OKAY);
      axr(LEVEL_LOW_ADDR, 32'h0000_007F, RESP_OKAY);
      axw(LEVEL_HIGH_ADDR, 32'h0000_002A, 4'hF, RESP_OKAY);
      axr(LEVEL_HIGH_ADDR, 32'h0000_002A, RESP_OKAY);
      ports(7'h2A, 7'h7F);
   endtask
   task automatic t_bits();
      axw(BIT_ACCESS_ADDR, 32'h0000_0006, 4'hF, RESP_OKAY);
      ports(7'h2A, 7'h3F);
      axw(LEVEL_LOW_ADDR, 32'h0, 4'h0, RESP_OKAY);
      axw(BIT_ACCESS_ADDR, 32'h0000_000F, 4'hF, RESP_OKAY);
      axr(BIT_ACCESS_ADDR, 32'h0, RESP_OKAY);
      axw(12'h100, 32'h0000_007F, 4'hF, RESP_SLVERR);
      axr(12'h100, 32'h0, RESP_SLVERR);
      ports(7'h2A, 7'h3F);
   endtask
   task automatic t_arb();
      axw(LEVEL_HIGH_ADDR, 32'h0000_0060, 4'hF, RESP_OKAY);
      axw(LEVEL_LOW_ADDR, 32'h0000_0042, 4'hF, RESP_OKAY);
      i_src.raise(0);
      wg(3'h0, 2'h0);
      i_src.raise(1);
      wg(3'h1, 2'h1);
      i_src.raise(1);
      ng();
      i_src.raise(5);
      wg(3'h5, 2'h2);
      i_src.raise(6);
      wg(3'h6, 2'h3);
      chk("in_service", 32'hF, 32'(insv));
      i_src.give_back();
      i_src.give_back();
      ng();
      i_src.give_back();
      wg(3'h1, 2'h1);
      i_src.give_back();
      i_src.give_back();
      ng();
      chk("in_service", 32'h0, 32'(insv));
      axr(STATUS_ADDR, 32'h0000_0110, RESP_OKAY);
   endtask
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial
   begin
      #100000;
      n_errors++;
      summarize();
   end
   initial
   begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      t_regs();
      t_bits();
      t_arb();
      summarize();
   end
endmodule
bind interrupt_priority_levels irq_level_checker i_chk (.SYS_CLK(SYS_CLK), .RST(RST),
   .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID),
   .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_ARVALID(S_AXI_ARVALID),
   .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RVALID(S_AXI_RVALID), .IRQ_REQ(IRQ_REQ),
   .IRQ_RETURN(IRQ_RETURN), .LEVEL_HIGH(LEVEL_HIGH), .LEVEL_LOW(LEVEL_LOW), .GRANT(GRANT),
   .GRANT_SRC(GRANT_SRC), .GRANT_LEVEL(GRANT_LEVEL), .IN_SERVICE(IN_SERVICE));
